// file: tb_vcrc_cap_reg.sv
`timescale 1ns/100ps
// exercises the capability word through configuration reads and writes
module tb_vcrc_cap_reg;
    import vcrc_pkg::*;
    localparam int MAX_CYC     = 200;
    logic          clk_sys_i   = 1'b0;
    logic          rst_i       = 1'b1;
    logic          cfg_rd_i    = 1'b0;
    logic          cfg_wr_i    = 1'b0;
    logic [11:0]   cfg_addr_i  = 12'h000;
    logic [31:0]   cfg_wdata_i = 32'h0000_0000;
    logic [31:0]   cfg_rdata_o;
    logic          cfg_hit_o;
    logic [7:0]    flags;
    logic [7:0]    loc;
    logic          sw;
    int            n_fail      = 0;
    int            checks_done = 0;
    int            cyc         = 0;

    // 25 MHz clock
    always #20 clk_sys_i = ~clk_sys_i;

    vcrc_cap_reg u_dut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .cfg_rd_i(cfg_rd_i), .cfg_wr_i(cfg_wr_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
        .cfg_hit_o(cfg_hit_o), .supported_scheme_flags_o(flags),
        .arbitration_table_location_o(loc), .switched_traffic_only_o(sw)
    );

    task automatic end_of_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // compares one value, zero-extended to a word
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one configuration cycle, then the registered answer
    task automatic acc(input logic rd, input logic wr, input logic [11:0] a, input logic hit, input logic [31:0] ex);
        cfg_rd_i    = rd;
        cfg_wr_i    = wr;
        cfg_addr_i  = a;
        cfg_wdata_i = 32'hFFFF_FFFF;
        @(posedge clk_sys_i);
        #1;
        chk("hit", {31'h0, hit}, {31'h0, cfg_hit_o});
        chk("rdata", ex, cfg_rdata_o);
    endtask

    // constant side outputs
    task automatic chk_side;
        chk("flags", 32'h0000_0001, {24'h0, flags});
        chk("location", 32'h0000_0000, {24'h0, loc});
        chk("switched", 32'h0000_0000, {31'h0, sw});
    endtask

    // cycle ceiling against hangs
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == MAX_CYC) begin
            n_fail++;
            end_of_test();
        end
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys_i);
        #1;
        chk_side();
        rst_i = 1'b0;
        acc(1'b0, 1'b0, 12'h160, 1'b0, 32'h0);
        for (int i = 0; i < 4; i++) acc(1'b1, 1'b0, VCRC_CAP_OFFSET + 12'(i), 1'b1, 32'h0000_0001);
        chk("tbl", 32'h0, {24'h0, cfg_rdata_o[31:24]});
        chk("rsvd23", 32'h0, {31'h0, cfg_rdata_o[23]});
        chk("slots", 32'h0, {25'h0, cfg_rdata_o[22:16]});
        chk("snoop", 32'h0, {31'h0, cfg_rdata_o[15]});
        chk("switch", 32'h0, {31'h0, cfg_rdata_o[14]});
        chk("rsvd13_8", 32'h0, {26'h0, cfg_rdata_o[13:8]});
        chk("rsvd7_6", 32'h0, {30'h0, cfg_rdata_o[7:6]});
        chk("scheme", 32'h1, {24'h0, cfg_rdata_o[7:0]});
        acc(1'b0, 1'b0, 12'h160, 1'b0, 32'h0);
        acc(1'b0, 1'b1, 12'h160, 1'b0, 32'h0);
        acc(1'b1, 1'b1, 12'h160, 1'b1, 32'h0000_0001);
        acc(1'b1, 1'b0, 12'h15C, 1'b0, 32'h0);
        acc(1'b1, 1'b0, 12'h164, 1'b0, 32'h0);
        acc(1'b1, 1'b0, 12'h960, 1'b0, 32'h0);
        chk_side();
        rst_i = 1'b1;
        acc(1'b1, 1'b0, 12'h160, 1'b0, 32'h0);
        rst_i = 1'b0;
        acc(1'b1, 1'b0, 12'h163, 1'b1, 32'h0000_0001);
        acc(1'b0, 1'b0, 12'h160, 1'b0, 32'h0);
        chk_side();
        end_of_test();
    end
endmodule

// file: vcrc_cap_reg.sv
`timescale 1ns/100ps
module vcrc_cap_reg
    import vcrc_pkg::*;
(
    input  wire logic        clk_sys_i,                    // configuration clock, 25 MHz
    input  wire logic        rst_i,                        // synchronous reset, active high
    input  wire logic        cfg_rd_i,                     // configuration read strobe
    input  wire logic        cfg_wr_i,                     // configuration write strobe
    input  wire logic [11:0] cfg_addr_i,                   // extended configuration byte address
    input  wire logic [31:0] cfg_wdata_i,                  // write data, ignored
    output logic      [31:0] cfg_rdata_o,                  // read data, registered
    output logic             cfg_hit_o,                    // read data valid for this register
    output logic      [7:0]  supported_scheme_flags_o,     // scheme flags
    output logic      [7:0]  arbitration_table_location_o, // table location
    output logic             switched_traffic_only_o       // switched traffic flag
);
    logic [31:0] cap_word;
    logic        addr_match;
    logic        read_take;

    // layout checks on the package constants; a bad edit there stops elaboration
    if (VCRC_TBL_LOC_LSB + 8 != 32) begin : g_bad_tbl_loc
        $error("table location field must fill the top byte");
    end
    if (VCRC_SLOTS_LSB + 7 != VCRC_RSVD23_BIT) begin : g_bad_slots
        $error("slot count field must end just below bit 23");
    end
    if (VCRC_SNOOP_REJ_BIT != VCRC_SWITCHED_BIT + 1) begin : g_bad_flags
        $error("snoop and switched bits must be neighbours");
    end
    if (VCRC_RSVD_LO_LSB != VCRC_SCHEME_LSB + 8) begin : g_bad_scheme
        $error("scheme byte must sit just below the low reserved bits");
    end
    if (VCRC_CAP_RESET != {VCRC_TBL_LOC_VAL, 1'b0, VCRC_SLOTS_VAL, 8'h00, VCRC_SCHEME_VAL}) begin : g_bad_reset
        $error("reset word disagrees with its fields");
    end

    // constant word source
    vcrc_cap_word u_word (
        .word_o (cap_word)
    );

    // address decode of the aligned word
    assign addr_match = (cfg_addr_i[11:2] == VCRC_CAP_OFFSET[11:2]);

    // a read is taken only when the strobe meets a matching address; writes never reach here
    assign read_take  = cfg_rd_i & addr_match;

    // read path; writes have no path into the word
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cfg_rdata_o <= 32'h0000_0000;
            cfg_hit_o   <= 1'b0;
        end else begin
            cfg_hit_o   <= read_take;
            cfg_rdata_o <= read_take ? cap_word : 32'h0000_0000;
        end
    end

    // field outputs from flip-flops
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            supported_scheme_flags_o     <= VCRC_CAP_RESET[7:0];
            arbitration_table_location_o <= VCRC_CAP_RESET[31:24];
            switched_traffic_only_o      <= 1'b0;
        end else begin
            supported_scheme_flags_o     <= cap_word[VCRC_SCHEME_LSB +: 8];
            arbitration_table_location_o <= cap_word[VCRC_TBL_LOC_LSB +: 8];
            switched_traffic_only_o      <= cap_word[VCRC_SWITCHED_BIT];
        end
    end

    // assertions
    property p_read_value;
        @(posedge clk_sys_i) disable iff (rst_i)
        (cfg_rd_i && addr_match) |=> (cfg_hit_o && cfg_rdata_o == VCRC_CAP_RESET);
    endproperty
    a_read_value: assert property (p_read_value) else $error("capability read value wrong");

    property p_write_ignored;
        @(posedge clk_sys_i) disable iff (rst_i)
        (cfg_wr_i && addr_match) ##1 (cfg_rd_i && addr_match) |=> cfg_rdata_o == VCRC_CAP_RESET;
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write altered capability");

    property p_top_byte;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> cfg_rdata_o[31:24] == 8'h00 && arbitration_table_location_o == 8'h00;
    endproperty
    a_top_byte: assert property (p_top_byte) else $error("table location not zero");

    property p_rsvd23;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> !cfg_rdata_o[23];
    endproperty
    a_rsvd23: assert property (p_rsvd23) else $error("bit 23 set");

    property p_slots;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> cfg_rdata_o[22:16] == 7'h00;
    endproperty
    a_slots: assert property (p_slots) else $error("slot count not zero");

    property p_snoop;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> !cfg_rdata_o[15];
    endproperty
    a_snoop: assert property (p_snoop) else $error("snoop bit set");

    property p_switched;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> !cfg_rdata_o[14] && !switched_traffic_only_o;
    endproperty
    a_switched: assert property (p_switched) else $error("switched bit set");

    property p_rsvd_lo;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> cfg_rdata_o[13:8] == 6'h00;
    endproperty
    a_rsvd_lo: assert property (p_rsvd_lo) else $error("bits 13:8 not zero");

    property p_onehot;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> $onehot(cfg_rdata_o[7:0]) && cfg_rdata_o[7:6] == 2'h0;
    endproperty
    a_onehot: assert property (p_onehot) else $error("scheme flags not one-hot");

    property p_scheme;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> cfg_rdata_o[7:0] == 8'h01 && supported_scheme_flags_o == 8'h01;
    endproperty
    a_scheme: assert property (p_scheme) else $error("scheme flags not 01h");

    property p_miss;
        @(posedge clk_sys_i) disable iff (rst_i)
        (cfg_rd_i && !addr_match) |=> !cfg_hit_o && cfg_rdata_o == 32'h0000_0000;
    endproperty
    a_miss: assert property (p_miss) else $error("unmatched read answered");

    // reset and handshake timing; p_hit_source and p_hit_pulse use read_take, the rest avoid the decode signals above
    property p_reset_outputs;
        @(posedge clk_sys_i)
        rst_i |=> !cfg_hit_o && cfg_rdata_o == 32'h0000_0000 && supported_scheme_flags_o == 8'h01
                  && arbitration_table_location_o == 8'h00 && !switched_traffic_only_o;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not at reset values");

    property p_hit_source;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> $past(read_take);
    endproperty
    a_hit_source: assert property (p_hit_source) else $error("answer without a matching read");

    property p_hit_pulse;
        @(posedge clk_sys_i) disable iff (rst_i)
        (cfg_hit_o && !read_take) |=> !cfg_hit_o;
    endproperty
    a_hit_pulse: assert property (p_hit_pulse) else $error("answer stood longer than one cycle");

    property p_idle_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        !cfg_hit_o |-> cfg_rdata_o == 32'h0000_0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not zero while idle");

    property p_wr_only;
        @(posedge clk_sys_i) disable iff (rst_i)
        (cfg_wr_i && !cfg_rd_i) |=> !cfg_hit_o && cfg_rdata_o == 32'h0000_0000;
    endproperty
    a_wr_only: assert property (p_wr_only) else $error("write produced an answer");

    property p_byte_offset;
        @(posedge clk_sys_i) disable iff (rst_i)
        (cfg_rd_i && cfg_addr_i[11:2] == 10'h058) |=> cfg_hit_o && cfg_rdata_o == 32'h0000_0001;
    endproperty
    a_byte_offset: assert property (p_byte_offset) else $error("read inside the word not answered");

    property p_miss_addr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (cfg_rd_i && cfg_addr_i[11:2] != 10'h058) |=> !cfg_hit_o;
    endproperty
    a_miss_addr: assert property (p_miss_addr) else $error("read outside the word answered");

    // constant content of the word and its side outputs
    property p_word_const;
        @(posedge clk_sys_i) disable iff (rst_i)
        cap_word == VCRC_CAP_RESET;
    endproperty
    a_word_const: assert property (p_word_const) else $error("assembled word not the fixed value");

    property p_side_const;
        @(posedge clk_sys_i) disable iff (rst_i)
        supported_scheme_flags_o == 8'h01 && arbitration_table_location_o == 8'h00 && !switched_traffic_only_o;
    endproperty
    a_side_const: assert property (p_side_const) else $error("side outputs not constant");

    property p_reserved_flags;
        @(posedge clk_sys_i) disable iff (rst_i)
        supported_scheme_flags_o[7:6] == 2'h0;
    endproperty
    a_reserved_flags: assert property (p_reserved_flags) else $error("reserved scheme flags set");

    property p_scheme_positions;
        @(posedge clk_sys_i) disable iff (rst_i)
        cfg_hit_o |-> cfg_rdata_o[VCRC_SCH_FIXED_RR] && cfg_rdata_o[VCRC_SCH_WRR256:VCRC_SCH_WRR32] == 5'h00;
    endproperty
    a_scheme_positions: assert property (p_scheme_positions) else $error("wrong scheme advertised");

    c_read:  cover property (@(posedge clk_sys_i) disable iff (rst_i) cfg_rd_i && addr_match);
    c_write: cover property (@(posedge clk_sys_i) disable iff (rst_i)
                             cfg_wr_i && addr_match && cfg_wdata_i != 32'h0000_0000);
    c_wr_rd: cover property (@(posedge clk_sys_i) disable iff (rst_i)
                             (cfg_wr_i && addr_match) ##1 (cfg_rd_i && addr_match));
    c_miss:  cover property (@(posedge clk_sys_i) disable iff (rst_i) cfg_rd_i && !addr_match);
    c_b2b:   cover property (@(posedge clk_sys_i) disable iff (rst_i) read_take ##1 read_take);
endmodule

// file: vcrc_cap_word.sv
`timescale 1ns/100ps
// assembles the constant capability word from its fields
module vcrc_cap_word
    import vcrc_pkg::*;
(
    output logic [31:0] word_o    // assembled capability word
);
    always_comb begin
        word_o                                        = 32'h0000_0000; // reserved bits zero
        word_o[VCRC_TBL_LOC_LSB +: 8]                 = VCRC_TBL_LOC_VAL;
        word_o[VCRC_SLOTS_LSB +: 7]                   = VCRC_SLOTS_VAL;
        word_o[VCRC_SNOOP_REJ_BIT]                    = 1'b0;
        word_o[VCRC_SWITCHED_BIT]                     = 1'b0;
        word_o[VCRC_SCHEME_LSB +: 8]                  = VCRC_SCHEME_VAL;
    end
endmodule

// file: vcrc_pkg.sv
package vcrc_pkg;
    // extended configuration offset of the capability word
    localparam logic [11:0] VCRC_CAP_OFFSET      = 12'h160;
    // field positions
    localparam int          VCRC_TBL_LOC_LSB     = 24;
    localparam int          VCRC_RSVD23_BIT      = 23;
    localparam int          VCRC_SLOTS_LSB       = 16;
    localparam int          VCRC_SNOOP_REJ_BIT   = 15;
    localparam int          VCRC_SWITCHED_BIT    = 14;
    localparam int          VCRC_RSVD_LO_LSB     = 8;
    localparam int          VCRC_SCHEME_LSB      = 0;
    // field values
    localparam logic [7:0]  VCRC_TBL_LOC_VAL     = 8'h00;
    localparam logic [6:0]  VCRC_SLOTS_VAL       = 7'h00;
    localparam logic [7:0]  VCRC_SCHEME_VAL      = 8'h01;
    // one-hot scheme flag positions
    localparam int          VCRC_SCH_FIXED_RR    = 0;
    localparam int          VCRC_SCH_WRR32       = 1;
    localparam int          VCRC_SCH_WRR64       = 2;
    localparam int          VCRC_SCH_WRR128      = 3;
    localparam int          VCRC_SCH_TWRR128     = 4;
    localparam int          VCRC_SCH_WRR256      = 5;
    // reset value of the word
    localparam logic [31:0] VCRC_CAP_RESET       = 32'h0000_0001;
endpackage
